// ==== core/pag_pkg.sv ====
package pag_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [2:0] PAG_ADDR_PIN_LEVEL = 3'h0;
	localparam logic [2:0] PAG_ADDR_OUTPUT_LATCH = 3'h1;
	localparam logic [2:0] PAG_ADDR_PIN_DIRECTION = 3'h2;
	localparam logic [2:0] PAG_ADDR_ANALOG_LOW = 3'h3;
	localparam logic [2:0] PAG_ADDR_ANALOG_HIGH = 3'h4;
	localparam logic [2:0] PAG_ADDR_OSC_MODE = 3'h5;
	localparam logic [2:0] PAG_ADDR_CAPTURE = 3'h6;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] PAG_RST_LATCH = 8'h00;
	localparam logic [7:0] PAG_RST_DIRECTION = 8'hFF;
	localparam logic [7:0] PAG_RST_ANALOG_LOW = 8'hFF;
	localparam logic [7:0] PAG_RST_ANALOG_HIGH = 8'h01;
	localparam logic [7:0] PAG_ANALOG_HIGH_MASK = 8'h01;

	// ****************************************
	// field positions and timing
	// ****************************************
	localparam int PAG_PIN_CAPTURE_INPUT_ONE = 2;
	localparam int PAG_PIN_CAPTURE_INPUT_TWO = 3;
	localparam int PAG_PIN_CAPTURE_INPUT_THREE = 4;
	localparam int PAG_PIN_SCHMITT = 4;
	localparam int PAG_PIN_SIX = 6;
	localparam int PAG_PIN_SEVEN = 7;
	localparam int PAG_CYCLE_DIV = 4;
	localparam int PAG_HALF_DIV = PAG_CYCLE_DIV / 2;
	localparam int PAG_SCHMITT_LEN = 3;

	// ****************************************
	// oscillator modes
	// ****************************************
	typedef enum logic [2:0] {
		PAG_OSC_XT = 3'h0,
		PAG_OSC_HS = 3'h1,
		PAG_OSC_LP = 3'h2,
		PAG_OSC_RC = 3'h3,
		PAG_OSC_RC_IO = 3'h4,
		PAG_OSC_INT_ONE = 3'h5,
		PAG_OSC_INT_IO_TWO = 3'h6,
		PAG_OSC_EC = 3'h7
	} pag_osc_mode_t;

	localparam logic [2:0] PAG_OSC_EC_IO = 3'h2;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pag_bus_req_t;

	typedef struct packed {
		logic [7:0] level_out;
		logic [7:0] level_oe;
	} pag_pin_drive_t;

	typedef struct packed {
		logic capture_input_one;
		logic capture_input_two;
		logic capture_input_three;
		logic encoder_index_in;
		logic encoder_phase_a_in;
		logic encoder_phase_b_in;
	} pag_periph_in_t;
endpackage

// ==== core/pag_port.sv ====
`timescale 1ns/1ns
module pag_port #(
	parameter int SCHMITT_LEN = pag_pkg::PAG_SCHMITT_LEN
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire pag_pkg::pag_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic [2:0] osc_mode,
	input wire logic ec_with_io,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output pag_pkg::pag_periph_in_t periph_in,
	output logic [7:0] analog_enable
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] output_latch;
		logic [7:0] pin_direction;
		logic [7:0] analog_select_low;
		logic [7:0] analog_select_high;
		logic [7:0] rdata;
		logic [7:0] pin_sample;
		logic [2:0] schmitt_hist;
		logic [2:0] cap_hist_a;
		logic [2:0] cap_hist_b;
		logic [2:0] cap_hist_c;
		logic [1:0] div_cnt;
		logic cycle_clk;
		logic schmitt_state;
		pag_pkg::pag_periph_in_t periph;
	} pag_state_t;

	pag_state_t st;
	pag_state_t next_st;

	logic pin6_io;
	logic pin7_io;
	logic pin6_clk;
	logic [7:0] io_mask;
	logic [7:0] dig_level;

	// a Schmitt buffer is modelled as a hysteresis filter: it flips
	// only when the last samples all agree, so slow edges do not chatter
	function automatic logic pag_schmitt(input logic [2:0] hist,
		input logic cur);
		if (&hist) begin
			pag_schmitt = 1'b1;
		end else if (~|hist) begin
			pag_schmitt = 1'b0;
		end else begin
			pag_schmitt = cur;
		end
	endfunction

	// ****************************************
	// oscillator pin use
	// ****************************************
	always_comb begin
		pin6_io = (osc_mode == pag_pkg::PAG_OSC_RC_IO) ||
			(osc_mode == pag_pkg::PAG_OSC_INT_IO_TWO) ||
			(osc_mode == pag_pkg::PAG_OSC_EC && ec_with_io);
		pin6_clk = (osc_mode == pag_pkg::PAG_OSC_RC) ||
			(osc_mode == pag_pkg::PAG_OSC_INT_ONE) ||
			(osc_mode == pag_pkg::PAG_OSC_EC && !ec_with_io);
		pin7_io = (osc_mode == pag_pkg::PAG_OSC_INT_ONE) ||
			(osc_mode == pag_pkg::PAG_OSC_INT_IO_TWO);
		io_mask = {pin7_io, pin6_io, 6'h3F};
	end

	// ****************************************
	// input path
	// ****************************************
	always_comb begin
		// pins 7 and 6 have no analog channel, so only 5:0 are gated
		dig_level = st.pin_sample &
			~{2'h0, st.analog_select_low[5:0]};
		dig_level[pag_pkg::PAG_PIN_SCHMITT] = st.schmitt_state &
			~st.analog_select_low[pag_pkg::PAG_PIN_SCHMITT];
		dig_level = dig_level & io_mask;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.pin_sample = pin_in;
		next_st.schmitt_hist = {st.schmitt_hist[1:0],
			pin_in[pag_pkg::PAG_PIN_SCHMITT]};
		next_st.schmitt_state = pag_schmitt(st.schmitt_hist,
			st.schmitt_state);
		next_st.cap_hist_a = {st.cap_hist_a[1:0],
			pin_in[pag_pkg::PAG_PIN_CAPTURE_INPUT_ONE]};
		next_st.cap_hist_b = {st.cap_hist_b[1:0],
			pin_in[pag_pkg::PAG_PIN_CAPTURE_INPUT_TWO]};
		next_st.cap_hist_c = {st.cap_hist_c[1:0],
			pin_in[pag_pkg::PAG_PIN_CAPTURE_INPUT_THREE]};
		// blocked inputs hold low so the capture logic sees no edges
		next_st.periph.capture_input_one = pag_schmitt(st.cap_hist_a,
			st.periph.capture_input_one) &
			~st.analog_select_low[pag_pkg::PAG_PIN_CAPTURE_INPUT_ONE];
		next_st.periph.capture_input_two = pag_schmitt(st.cap_hist_b,
			st.periph.capture_input_two) &
			~st.analog_select_low[pag_pkg::PAG_PIN_CAPTURE_INPUT_TWO];
		next_st.periph.capture_input_three = pag_schmitt(st.cap_hist_c,
			st.periph.capture_input_three) &
			~st.analog_select_low[pag_pkg::PAG_PIN_CAPTURE_INPUT_THREE];
		next_st.periph.encoder_index_in =
			next_st.periph.capture_input_one;
		next_st.periph.encoder_phase_a_in =
			next_st.periph.capture_input_two;
		next_st.periph.encoder_phase_b_in =
			next_st.periph.capture_input_three;

		// cycle clock: toggles every half period of osc/4
		if (st.div_cnt == 2'(pag_pkg::PAG_HALF_DIV - 1)) begin
			next_st.div_cnt = 2'h0;
			next_st.cycle_clk = ~st.cycle_clk;
		end else begin
			next_st.div_cnt = st.div_cnt + 2'h1;
		end

		if (bus_req.wr) begin
			unique case (bus_req.addr)
				pag_pkg::PAG_ADDR_PIN_LEVEL,
				pag_pkg::PAG_ADDR_OUTPUT_LATCH: begin
					next_st.output_latch = bus_req.wdata;
				end
				pag_pkg::PAG_ADDR_PIN_DIRECTION: begin
					next_st.pin_direction = bus_req.wdata;
				end
				pag_pkg::PAG_ADDR_ANALOG_LOW: begin
					next_st.analog_select_low = bus_req.wdata;
				end
				pag_pkg::PAG_ADDR_ANALOG_HIGH: begin
					next_st.analog_select_high = bus_req.wdata &
						pag_pkg::PAG_ANALOG_HIGH_MASK;
				end
				default: begin
				end
			endcase
		end

		next_st.rdata = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				pag_pkg::PAG_ADDR_PIN_LEVEL: begin
					next_st.rdata = dig_level;
				end
				pag_pkg::PAG_ADDR_OUTPUT_LATCH: begin
					next_st.rdata = st.output_latch & io_mask;
				end
				pag_pkg::PAG_ADDR_PIN_DIRECTION: begin
					next_st.rdata = st.pin_direction & io_mask;
				end
				pag_pkg::PAG_ADDR_ANALOG_LOW: begin
					next_st.rdata = st.analog_select_low;
				end
				pag_pkg::PAG_ADDR_ANALOG_HIGH: begin
					next_st.rdata = st.analog_select_high;
				end
				pag_pkg::PAG_ADDR_OSC_MODE: begin
					next_st.rdata = {4'h0, ec_with_io, osc_mode};
				end
				pag_pkg::PAG_ADDR_CAPTURE: begin
					next_st.rdata = {2'h0, st.periph};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.output_latch <= pag_pkg::PAG_RST_LATCH;
			st.pin_direction <= pag_pkg::PAG_RST_DIRECTION;
			st.analog_select_low <= pag_pkg::PAG_RST_ANALOG_LOW;
			st.analog_select_high <= pag_pkg::PAG_RST_ANALOG_HIGH;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	always_comb begin
		// analog selection does not gate the output driver
		pin_out = st.output_latch;
		pin_oe = ~st.pin_direction & io_mask;
		if (pin6_clk) begin
			pin_out[pag_pkg::PAG_PIN_SIX] = st.cycle_clk;
			pin_oe[pag_pkg::PAG_PIN_SIX] = 1'b1;
		end
	end

	assign bus_rdata = st.rdata;
	assign periph_in = st.periph;
	assign analog_enable = st.analog_select_low;

	// ****************************************
	// checks
	// ****************************************
	out_latch_drive_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!st.pin_direction[0] |->
		pin_oe[0] && pin_out[0] == st.output_latch[0])
		else $error("output pin not driven from latch");

	analog_read_zero_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(bus_req.rd && bus_req.addr == pag_pkg::PAG_ADDR_PIN_LEVEL &&
		st.analog_select_low[1]) |=> !bus_rdata[1])
		else $error("analog pin read nonzero");

	reset_analog_a: assert property (
		@(posedge sys_clk)
		$rose(rst_b) |-> analog_enable == pag_pkg::PAG_RST_ANALOG_LOW)
		else $error("analog select not default after reset");

	cap_block_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		st.analog_select_low[pag_pkg::PAG_PIN_CAPTURE_INPUT_ONE] |=>
		!periph_in.capture_input_one)
		else $error("capture input not blocked");

	schmitt_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(st.schmitt_hist != 3'h7 && st.schmitt_hist != 3'h0) |=>
		$stable(st.schmitt_state))
		else $error("schmitt input switched without agreement");

	pin6_io_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(!pin6_io && !pin6_clk) |-> !pin_oe[pag_pkg::PAG_PIN_SIX])
		else $error("pin six driven outside io mode");

	cycle_clk_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		($rose(st.cycle_clk) && pin6_clk) |-> ##2 $fell(st.cycle_clk))
		else $error("cycle clock not osc over four");

	pin7_io_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!pin7_io |-> !pin_oe[pag_pkg::PAG_PIN_SEVEN])
		else $error("pin seven driven in external osc mode");

	osc_dir_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		pin6_clk |-> pin_oe[pag_pkg::PAG_PIN_SIX])
		else $error("clock pin direction followed direction bit");

	upper_zero_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(bus_req.rd && !pin7_io && bus_req.addr <= 3'h2) |=> !bus_rdata[7])
		else $error("pin seven bits not read as zero");

	latch_write_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(bus_req.wr && bus_req.addr == pag_pkg::PAG_ADDR_PIN_LEVEL) |=>
		st.output_latch == $past(bus_req.wdata))
		else $error("pin level write missed latch");
endmodule

// ==== verification/pag_board.sv ====
`timescale 1ns/1ns
module pag_board (
	input wire logic [7:0] ext_level,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	output logic [7:0] pin_in
);
	// ****************************************
	// pin wire level
	// ****************************************
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== verification/port_a_gpio_with_analog_mux_tb_top.sv ====
`timescale 1ns/1ns
module port_a_gpio_with_analog_mux_tb_top;
	logic sys_clk, rst_b;
	pag_pkg::pag_bus_req_t bus_req;
	pag_pkg::pag_periph_in_t periph_in;
	logic [7:0] bus_rdata, pin_in, pin_out, pin_oe, analog_enable, ext_level;
	logic [2:0] osc_mode;
	logic ec_with_io, io7, io6, ck, b;
	logic [7:0] d, v, mask, e;
	logic [7:0] rst_exp [6];
	logic [2:0] rst_addr [6];
	int err_total = 0, checks_done = 0, cycles = 0;
	int m_lat = pag_pkg::PAG_RST_LATCH, m_dir = pag_pkg::PAG_RST_DIRECTION;
	int m_ans = pag_pkg::PAG_RST_ANALOG_LOW;

	// ****************************************
	// design and board
	// ****************************************
	pag_port pag_port_i (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.osc_mode(osc_mode),
		.ec_with_io(ec_with_io),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.periph_in(periph_in),
		.analog_enable(analog_enable)
	);
	pag_board pag_board_i (
		.ext_level(ext_level),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_in(pin_in)
	);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			report_and_stop();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] r);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		r = bus_rdata;
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d of %0d comparisons", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		bus_req = '0;
		osc_mode = 3'h6;
		ec_with_io = 1'b0;
		ext_level = 8'h00;
		rst_addr = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		rst_exp = '{8'h00, 8'(m_lat), 8'(m_dir), 8'(m_ans),
			pag_pkg::PAG_RST_ANALOG_HIGH, 8'h00};
		void'($urandom(64126));
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk(analog_enable, 8'(m_ans));
		for (int i = 0; i < 6; i++) begin
			rd(rst_addr[i], d);
			chk(d, rst_exp[i]);
		end
		// outputs under analog selection still follow the latch
		v = 8'($urandom);
		wr(pag_pkg::PAG_ADDR_PIN_DIRECTION, 8'h00);
		wr(pag_pkg::PAG_ADDR_PIN_LEVEL, v);
		m_lat = v;
		rd(pag_pkg::PAG_ADDR_OUTPUT_LATCH, d);
		chk(d, 8'(m_lat));
		chk(pin_out, 8'(m_lat));
		chk(pin_oe, 8'hFF);
		// inputs, then analog blocking of reads and captures
		wr(pag_pkg::PAG_ADDR_PIN_DIRECTION, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			m_ans = (k == 0) ? 8'h00 : 8'h1C;
			wr(pag_pkg::PAG_ADDR_ANALOG_LOW, 8'(m_ans));
			@(posedge sys_clk);
			ext_level <= 8'($urandom);
			repeat (10) @(posedge sys_clk);
			rd(pag_pkg::PAG_ADDR_PIN_LEVEL, d);
			e = ext_level & ~8'(m_ans);
			chk(d, e);
			mask = {2'h0, e[2], e[3], e[4], e[2], e[3], e[4]};
			chk({2'h0, periph_in}, mask);
			rd(pag_pkg::PAG_ADDR_CAPTURE, d);
			chk(d, mask);
		end
		// oscillator modes against the upper pins
		wr(pag_pkg::PAG_ADDR_OUTPUT_LATCH, 8'hFF);
		for (int i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			osc_mode <= 3'((i > 7) ? 7 : i);
			ec_with_io <= (i == 8);
			io7 = (i == 5 || i == 6);
			io6 = (i == 4 || i == 6 || i == 8);
			ck = (i == 3 || i == 5 || i == 7);
			mask = {io7, io6, 6'h3F};
			wr(pag_pkg::PAG_ADDR_PIN_DIRECTION, 8'hFF);
			rd(pag_pkg::PAG_ADDR_PIN_DIRECTION, d);
			chk(d, mask);
			rd(pag_pkg::PAG_ADDR_OUTPUT_LATCH, d);
			chk(d, mask);
			rd(pag_pkg::PAG_ADDR_OSC_MODE, d);
			chk(d, 8'((i > 7) ? 15 : i));
			chk({6'h0, pin_oe[7:6]}, {7'h00, ck});
			wr(pag_pkg::PAG_ADDR_PIN_DIRECTION, 8'h00);
			chk({6'h0, pin_oe[7:6]}, {6'h00, io7, io6 | ck});
		end
		// cycle clock: a quarter of the oscillator rate
		@(posedge sys_clk);
		osc_mode <= 3'h3;
		repeat (4) @(posedge sys_clk);
		#1;
		b = pin_out[6];
		repeat (2) @(posedge sys_clk);
		#1;
		chk({7'h00, pin_out[6]}, {7'h00, ~b});
		repeat (2) @(posedge sys_clk);
		#1;
		chk({7'h00, pin_out[6]}, {7'h00, b});
		report_and_stop();
	end
endmodule
